// File: meter_cfg.svh
// constants: offsets, field positions, reset values and times of the meter block
`ifndef METER_CFG_SVH
`define METER_CFG_SVH
// ----------------------------------------------------------------------------
// clock and times
// ----------------------------------------------------------------------------
`define CLK_HZ            10000000
`define TICK_S            1
`define PW_SHORT_MS       32
`define PW_LONG_MS        100
`define DISP_OFF_S        9'd480
`define KEY_FAST_S        9'd240
`define HEARTBEAT_S       5'd30
`define INT_FAST_S        7'd4
`define INT_NORMAL_S      7'd32
`define INT_ADAPT_MAX_S   7'd64
`define LEAK_HALF_S       13'd1800
`define LEAK_ONE_S        13'd3600
`define LEAK_TWO_S        13'd7200
`define LEAK_HALF_N       6'd48
`define LEAK_ONE_N        6'd24
`define LEAK_TWO_N        6'd12
// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define ADR_CONFIG        8'h00
`define ADR_THRESH        8'h04
`define ADR_PRESCALE      8'h08
`define ADR_COUNT_A       8'h0C
`define ADR_COUNT_B       8'h10
`define ADR_STATUS        8'h14
`define ADR_OUT_CTRL      8'h18
`define ADR_HEAT          8'h1C
`define ADR_COOL          8'h20
`define ADR_VOL           8'h24
// ----------------------------------------------------------------------------
// config fields and reset values
// ----------------------------------------------------------------------------
`define CFG_PW_LSB        0
`define CFG_INT_LSB       8
`define CFG_LEAK_LSB      12
`define CFG_LEAKB_BIT     16
`define PW_CODE_RST       8'h5F
`define PW_CODE_LONG      8'h60
`define PW_CODE_CTRL      8'h63
`define INT_CODE_RST      3'h1
`define LEAK_CODE_RST     2'h2
`define PRESCALE_RST      16'h0001
`define THRESH_RST        16'h0010
`endif

// File: meter_pkg.sv
// types shared by the meter integration and pulse block
package meter_pkg;
    typedef enum logic [1:0] {
        SRC_HEAT = 2'b00,
        SRC_COOL = 2'b01,
        SRC_VOL  = 2'b10
    } src_e;

    typedef struct packed {
        logic [23:0]       div_cnt;
        logic              sec;
        logic [2:0]        key_sync;
        logic [2:0]        pa_sync;
        logic [2:0]        pb_sync;
        logic [7:0]        pw_code;
        logic [2:0]        int_code;
        logic [1:0]        leak_code;
        logic              leak_b_en;
        logic [15:0]       thresh;
        logic [15:0]       presc_a;
        logic [15:0]       presc_b;
        logic [15:0]       pre_a;
        logic [15:0]       pre_b;
        logic [31:0]       cnt_a;
        logic [31:0]       cnt_b;
        logic [31:0]       heat;
        logic [31:0]       cool;
        logic [31:0]       vol;
        logic [8:0]        key_timer;
        logic [6:0]        sec_cnt;
        logic [6:0]        interval;
        logic [6:0]        adapt;
        logic              changed;
        logic [15:0]       prev_flow;
        logic [15:0]       prev_power;
        logic              integrate;
        logic              display_on;
        logic [4:0]        hb_cnt;
        logic              heartbeat;
        logic [12:0]       leak_sec;
        logic              leak_seen;
        logic [5:0]        leak_cnt;
        logic              leak_info;
        logic [1:0][15:0]  pend;
        logic [1:0][23:0]  pw_cnt;
        logic [1:0]        out;
        logic [1:0]        ctrl;
        logic              ack;
        logic [31:0]       dat;
    } state_s;
endpackage : meter_pkg

// File: meter_integration_and_pulse_ctrl.sv
// integration scheduler, leak monitor and pulse-output router of a heat meter
//
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "meter_cfg.svh"

module meter_integration_and_pulse_ctrl
    import meter_pkg::*;
#(
    parameter int unsigned METER_TYPE      = 1,
    parameter int unsigned SEC_CYCLES      = `CLK_HZ * `TICK_S,
    parameter int unsigned PW_SHORT_CYCLES = `PW_SHORT_MS * (`CLK_HZ / 1000),
    parameter int unsigned PW_LONG_CYCLES  = `PW_LONG_MS * (`CLK_HZ / 1000)
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        key_i,
    input  wire logic        pulse_a_i,
    input  wire logic        pulse_b_i,
    input  wire logic [15:0] flow_i,
    input  wire logic [15:0] power_i,
    input  wire logic        heat_inc_i,
    input  wire logic        cool_inc_i,
    input  wire logic        vol_inc_i,
    output logic             integrate_o,
    output logic             display_on_o,
    output logic             heartbeat_o,
    output logic             leak_info_o,
    output logic             pulse_c_o,
    output logic             pulse_d_o
);

    // ------------------------------------------------------------------------
    // fixed routing
    // ------------------------------------------------------------------------
    function automatic src_e route(input int unsigned t, input bit chan_d);
        src_e s;
        s = SRC_VOL;
        unique case (t)
            1, 2, 4: s = chan_d ? SRC_VOL  : SRC_HEAT;
            3, 6:    s = chan_d ? SRC_COOL : SRC_HEAT;
            5:       s = chan_d ? SRC_VOL  : SRC_COOL;
            default: s = SRC_VOL;
        endcase
        return s;
    endfunction : route

    // a parameter, not a register: routing is frozen at build time
    localparam src_e SRC_C = route(METER_TYPE, 1'b0);
    localparam src_e SRC_D = route(METER_TYPE, 1'b1);

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                m[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return m;
    endfunction : merge

    function automatic logic [15:0] absdiff(input logic [15:0] a,
                                            input logic [15:0] b);
        return (a > b) ? a - b : b - a;
    endfunction : absdiff

    state_s r;
    state_s n;

    logic        req;
    logic        key_edge;
    logic        pa_edge;
    logic        pb_edge;
    logic        disp_off_mode;
    logic        key_fast;
    logic [6:0]  mode_int;
    logic [6:0]  cur_int;
    logic        change;
    logic [12:0] leak_len;
    logic [5:0]  leak_n;
    logic [1:0]  inc;
    logic [23:0] pw_len;
    logic [31:0] cfg_word;
    logic [31:0] wv;

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        n = r;
        req = wb_cyc_i && wb_stb_i && !r.ack;
        // first sync stage is only read by the second
        n.key_sync = {r.key_sync[1:0], key_i};
        n.pa_sync  = {r.pa_sync[1:0], pulse_a_i};
        n.pb_sync  = {r.pb_sync[1:0], pulse_b_i};
        key_edge = r.key_sync[1] && !r.key_sync[2];
        pa_edge  = r.pa_sync[1] && !r.pa_sync[2];
        pb_edge  = r.pb_sync[1] && !r.pb_sync[2];

        // one-second enable
        n.sec = 1'b0;
        if (r.div_cnt >= 24'(SEC_CYCLES - 1)) begin
            n.div_cnt = 24'h000000;
            n.sec     = 1'b1;
        end else begin
            n.div_cnt = r.div_cnt + 24'h000001;
        end

        // --------------------------------------------------------------------
        // integration scheduler
        // --------------------------------------------------------------------
        disp_off_mode = r.int_code[2];
        key_fast = r.key_timer < `KEY_FAST_S;
        unique case (r.int_code[1:0])
            2'b01:   mode_int = r.adapt;
            2'b11:   mode_int = `INT_FAST_S;
            default: mode_int = `INT_NORMAL_S;
        endcase
        cur_int = key_fast ? `INT_FAST_S : mode_int;
        n.interval = cur_int;
        n.integrate = 1'b0;
        change = (absdiff(flow_i, r.prev_flow) > r.thresh) ||
                 (absdiff(power_i, r.prev_power) > r.thresh);
        if (key_edge) begin
            n.key_timer = 9'h000;
        end else if (r.sec && r.key_timer != `DISP_OFF_S) begin
            n.key_timer = r.key_timer + 9'h001;
        end
        if (r.sec) begin
            n.prev_flow  = flow_i;
            n.prev_power = power_i;
            if (change) begin
                n.adapt   = `INT_FAST_S;
                n.changed = 1'b1;
            end
            if (r.sec_cnt + 7'h01 >= cur_int) begin
                n.sec_cnt   = 7'h00;
                n.integrate = 1'b1;
                n.changed   = 1'b0;
                if (!change && !r.changed &&
                    r.adapt != `INT_ADAPT_MAX_S) begin
                    n.adapt = {r.adapt[5:0], 1'b0};
                end
            end else begin
                n.sec_cnt = r.sec_cnt + 7'h01;
            end
        end
        n.display_on = !disp_off_mode ||
                       (n.key_timer < `DISP_OFF_S);
        n.heartbeat = 1'b0;
        if (n.display_on) begin
            n.hb_cnt = 5'h00;
        end else if (r.sec) begin
            if (r.hb_cnt + 5'h01 >= `HEARTBEAT_S) begin
                n.hb_cnt    = 5'h00;
                n.heartbeat = 1'b1;
            end else begin
                n.hb_cnt = r.hb_cnt + 5'h01;
            end
        end else begin
            n.heartbeat = r.heartbeat;                    // one second lit
        end

        // --------------------------------------------------------------------
        // leak monitor
        // --------------------------------------------------------------------
        unique case (r.leak_code)
            2'b01:   begin leak_len = `LEAK_HALF_S; leak_n = `LEAK_HALF_N; end
            2'b11:   begin leak_len = `LEAK_TWO_S;  leak_n = `LEAK_TWO_N;  end
            default: begin leak_len = `LEAK_ONE_S;  leak_n = `LEAK_ONE_N;  end
        endcase
        if (pa_edge || (r.leak_b_en && pb_edge)) begin
            n.leak_seen = 1'b1;
        end
        if (r.leak_code == 2'b00) begin
            n.leak_sec  = 13'h0000;
            n.leak_cnt  = 6'h00;
            n.leak_seen = 1'b0;
            n.leak_info = 1'b0;
        end else if (r.sec) begin
            if (r.leak_sec + 13'h0001 >= leak_len) begin
                n.leak_sec  = 13'h0000;
                n.leak_seen = 1'b0;
                if (r.leak_seen || pa_edge) begin
                    if (r.leak_cnt + 6'h01 >= leak_n) begin
                        n.leak_cnt  = leak_n;
                        n.leak_info = 1'b1;
                    end else begin
                        n.leak_cnt = r.leak_cnt + 6'h01;
                    end
                end else begin
                    n.leak_cnt  = 6'h00;
                    n.leak_info = 1'b0;
                end
            end else begin
                n.leak_sec = r.leak_sec + 13'h0001;
            end
        end

        // --------------------------------------------------------------------
        // pulse input prescalers
        // --------------------------------------------------------------------
        if (pa_edge) begin
            if (r.pre_a + 16'h0001 >= r.presc_a) begin
                n.pre_a = 16'h0000;
                n.cnt_a = r.cnt_a + 32'h00000001;
            end else begin
                n.pre_a = r.pre_a + 16'h0001;
            end
        end
        if (pb_edge) begin
            if (r.pre_b + 16'h0001 >= r.presc_b) begin
                n.pre_b = 16'h0000;
                n.cnt_b = r.cnt_b + 32'h00000001;
            end else begin
                n.pre_b = r.pre_b + 16'h0001;
            end
        end

        // --------------------------------------------------------------------
        // accumulators and pulse outputs
        // --------------------------------------------------------------------
        if (heat_inc_i) n.heat = r.heat + 32'h00000001;
        if (cool_inc_i) n.cool = r.cool + 32'h00000001;
        if (vol_inc_i)  n.vol  = r.vol + 32'h00000001;
        inc[0] = (SRC_C == SRC_HEAT) ? heat_inc_i :
                 (SRC_C == SRC_COOL) ? cool_inc_i : vol_inc_i;
        inc[1] = (SRC_D == SRC_HEAT) ? heat_inc_i :
                 (SRC_D == SRC_COOL) ? cool_inc_i : vol_inc_i;
        pw_len = (r.pw_code == `PW_CODE_LONG) ? 24'(PW_LONG_CYCLES)
                                              : 24'(PW_SHORT_CYCLES);
        for (int c = 0; c < 2; c++) begin
            // one lsd unit queues one pulse; high then equal low gap
            n.pend[c] = r.pend[c] + {15'h0000, inc[c]};
            if (r.pw_cnt[c] != 24'h000000) begin
                n.pw_cnt[c] = r.pw_cnt[c] - 24'h000001;
            end else if (r.pend[c] != 16'h0000 &&
                         r.pw_code != `PW_CODE_CTRL) begin
                n.pw_cnt[c] = {pw_len[22:0], 1'b0} - 24'h000001;
                n.pend[c]   = r.pend[c] - 16'h0001 + {15'h0000, inc[c]};
            end
            if (r.pw_code == `PW_CODE_CTRL) begin
                n.out[c] = r.ctrl[c];
            end else begin
                n.out[c] = n.pw_cnt[c] >= pw_len;
            end
        end

        // --------------------------------------------------------------------
        // wishbone slave
        // --------------------------------------------------------------------
        n.ack = req;
        cfg_word = {15'h0000, r.leak_b_en, 2'b00, r.leak_code,
                    1'b0, r.int_code, r.pw_code};
        if (req && wb_we_i) begin
            unique case (wb_adr_i)
                `ADR_CONFIG: begin
                    wv = merge(cfg_word, wb_dat_i, wb_sel_i);
                    n.pw_code   = wv[`CFG_PW_LSB +: 8];
                    n.int_code  = wv[`CFG_INT_LSB +: 3];
                    n.leak_code = wv[`CFG_LEAK_LSB +: 2];
                    n.leak_b_en = wv[`CFG_LEAKB_BIT];
                end
                `ADR_THRESH: begin
                    wv = merge({16'h0000, r.thresh}, wb_dat_i, wb_sel_i);
                    n.thresh = wv[15:0];
                end
                `ADR_PRESCALE: begin
                    wv = merge({r.presc_b, r.presc_a}, wb_dat_i, wb_sel_i);
                    n.presc_a = wv[15:0];
                    n.presc_b = wv[31:16];
                end
                `ADR_COUNT_A: begin
                    wv = merge(r.cnt_a, wb_dat_i, wb_sel_i);
                    n.cnt_a = wv;
                end
                `ADR_COUNT_B: begin
                    wv = merge(r.cnt_b, wb_dat_i, wb_sel_i);
                    n.cnt_b = wv;
                end
                `ADR_OUT_CTRL: begin
                    wv = merge({30'h00000000, r.ctrl}, wb_dat_i, wb_sel_i);
                    n.ctrl = wv[1:0];
                end
                default: wv = 32'h00000000;
            endcase
        end else begin
            wv = 32'h00000000;
        end
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                `ADR_CONFIG:   n.dat = cfg_word | (32'(METER_TYPE) << 24);
                `ADR_THRESH:   n.dat = {16'h0000, r.thresh};
                `ADR_PRESCALE: n.dat = {r.presc_b, r.presc_a};
                `ADR_COUNT_A:  n.dat = r.cnt_a;
                `ADR_COUNT_B:  n.dat = r.cnt_b;
                `ADR_STATUS:   n.dat = {16'h0000, r.out, r.leak_info,
                                        r.heartbeat, r.display_on,
                                        key_fast, 3'h0, r.interval};
                `ADR_OUT_CTRL: n.dat = {30'h00000000, r.ctrl};
                `ADR_HEAT:     n.dat = r.heat;
                `ADR_COOL:     n.dat = r.cool;
                `ADR_VOL:      n.dat = r.vol;
                default:       n.dat = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r           <= '0;
            r.pw_code   <= `PW_CODE_RST;
            r.int_code  <= `INT_CODE_RST;
            r.leak_code <= `LEAK_CODE_RST;
            r.presc_a   <= `PRESCALE_RST;
            r.presc_b   <= `PRESCALE_RST;
            r.thresh    <= `THRESH_RST;
            r.adapt     <= `INT_FAST_S;
            r.interval  <= `INT_FAST_S;
            r.key_timer <= `DISP_OFF_S;
            r.display_on <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign wb_dat_o     = r.dat;
    assign wb_ack_o     = r.ack;
    assign integrate_o  = r.integrate;
    assign display_on_o = r.display_on;
    assign heartbeat_o  = r.heartbeat;
    assign leak_info_o  = r.leak_info;
    assign pulse_c_o    = r.out[0];
    assign pulse_d_o    = r.out[1];

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_acked;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    chk_bus_ack_once: assert property (s_req |=> s_acked)
        else $error("ack not a single cycle after request");
    chk_display_stays_on: assert property (
        !r.int_code[2] |=> display_on_o)
        else $error("display off in a display-on mode");
    chk_display_timeout: assert property (
        r.int_code[2] && r.key_timer == `DISP_OFF_S && !key_edge
        |=> !display_on_o)
        else $error("display still on after key timeout");
    chk_heartbeat_dark: assert property (
        heartbeat_o |-> !display_on_o)
        else $error("heartbeat while display on");
    chk_key_fast_int: assert property (
        key_edge |=> ##1 r.interval == `INT_FAST_S)
        else $error("key did not force 4 s interval");
    chk_normal_int: assert property (
        r.int_code[1:0] == 2'b10 && !key_fast |=> r.interval == `INT_NORMAL_S)
        else $error("normal interval not 32 s");
    chk_adapt_steps: assert property (
        r.adapt == 7'd4 || r.adapt == 7'd8 || r.adapt == 7'd16 ||
        r.adapt == 7'd32 || r.adapt == 7'd64)
        else $error("adaptive interval off the doubling ladder");
    chk_leak_off: assert property (
        r.leak_code == 2'b00 |=> !leak_info_o)
        else $error("leak flag with monitoring disabled");
    chk_leak_clear: assert property (
        r.sec && r.leak_code != 2'b00 && r.leak_sec + 13'h0001 >= leak_len &&
        !r.leak_seen && !pa_edge |=> !leak_info_o)
        else $error("leak flag kept after an empty interval");
    chk_ctrl_output: assert property (
        r.pw_code == `PW_CODE_CTRL |=> pulse_c_o == $past(r.ctrl[0]))
        else $error("controlled output does not follow data");

endmodule : meter_integration_and_pulse_ctrl

// File: meter_far_side.sv
// far side model: water meter pulse source and pulse counting equipment
`timescale 1ns/1ps
module meter_far_side (
    input  wire logic clk_i,
    input  wire logic pulse_c_i,
    input  wire logic pulse_d_i,
    output logic      pulse_a_o
);
    int n_c = 0;
    int n_d = 0;
    initial pulse_a_o = 1'b0;
    // counts closures only; width is not judged here
    always @(posedge clk_i) begin
        if ($rose(pulse_c_i)) n_c <= n_c + 1;
        if ($rose(pulse_d_i)) n_d <= n_d + 1;
    end
    task automatic send(input int n, input int gap);
        repeat (n) begin
            pulse_a_o <= 1'b1;
            repeat (gap) @(posedge clk_i);
            pulse_a_o <= 1'b0;
            repeat (gap) @(posedge clk_i);
        end
    endtask : send
endmodule : meter_far_side

// File: meter_integration_and_pulse_ctrl_test.sv
// self-checking bench of the meter integration and pulse block
`timescale 1ns/1ps
`include "meter_cfg.svh"
module meter_integration_and_pulse_ctrl_test;
    localparam int SEC = 20;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  sel = 4'h0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, rd;
    logic        ack, integ, pc, pd, pa, disp, hb, leak;
    logic        key = 1'b0;
    logic [15:0] flow = 16'h0000;
    logic        heat = 1'b0;
    logic        vol = 1'b0;
    int          failures = 0;
    int          n_tests = 0;
    int          n, v, nh, nv;
    int          mode[4] = '{3, 7, 2, 6};
    int          len[4] = '{4, 4, 32, 32};
    always #50 clk_i = ~clk_i;
    meter_integration_and_pulse_ctrl #(.SEC_CYCLES(SEC),
        .PW_SHORT_CYCLES(4), .PW_LONG_CYCLES(8))
        meter_integration_and_pulse_ctrl_inst (
        .clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .key_i(key), .pulse_a_i(pa), .pulse_b_i(1'b0),
        .flow_i(flow), .power_i(16'h0000), .heat_inc_i(heat),
        .cool_inc_i(1'b0), .vol_inc_i(vol), .integrate_o(integ),
        .display_on_o(disp), .heartbeat_o(hb), .leak_info_o(leak),
        .pulse_c_o(pc), .pulse_d_o(pd));
    meter_far_side meter_far_side_inst (.clk_i, .pulse_c_i(pc),
        .pulse_d_i(pd), .pulse_a_o(pa));
    task automatic check(input string nm, input logic [31:0] s,
                         input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do @(posedge clk_i); while (ack !== 1'b1 && ++k < 50);
        if (k >= 50) failures++;
        rd = rdat;
        cyc <= 1'b0;
        sel <= 4'h0;
        @(posedge clk_i);
    endtask : wb
    // sync waits for an interval end, gap counts cycles to the next one
    task automatic sync;
        n = 0;
        do @(posedge clk_i); while (integ !== 1'b1 && ++n < 2000);
    endtask : sync
    task automatic gap(output int c);
        c = 0;
        do begin
            @(posedge clk_i);
            c++;
        end while (integ !== 1'b1 && c < 2000);
    endtask : gap
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (40000) @(posedge clk_i);
        failures++;
        final_report();
    end
    initial begin
        v = $urandom(32'hBAE89A49);
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, `ADR_CONFIG, 32'h0);
        check("config", rd, 32'h0100215F);
        wb(1'b0, 8'h40, 32'h0);
        check("unmapped", rd, 32'h0);
        sync();
        for (int i = 0; i < 5; i++) begin
            gap(n);
            check("adaptive", n, SEC * (i < 3 ? 8 << i : 64));
        end
        flow <= 16'($urandom_range(16'hFFFF, 16'h0011));
        for (int i = 0; i < 3; i++) begin
            gap(n);
            check("adapt change", n, SEC * (i < 2 ? 4 : 8));
        end
        $display("test adaptive done");
        foreach (mode[i]) begin
            wb(1'b1, `ADR_CONFIG, 32'h0000205F | (mode[i] << 8));
            sync();
            gap(n);
            check("interval", n, SEC * len[i]);
            check("display", disp, mode[i] < 4);
        end
        $display("test modes done");
        n = 0;
        do @(posedge clk_i); while (hb !== 1'b1 && ++n < 2000);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (hb === 1'b1 && n < 2000);
        check("beat high", n, SEC);
        do begin
            @(posedge clk_i);
            n++;
        end while (hb !== 1'b1 && n < 2000);
        check("beat period", n, SEC * 30);
        sync();
        key <= 1'b1;
        gap(n);
        key <= 1'b0;
        check("key interval", n, SEC * 4);
        check("key display", disp, 1);
        v = n;
        do begin
            @(posedge clk_i);
            v++;
        end while (disp === 1'b1 && v < 20000);
        check("display off", v, SEC * 480);
        sync();
        gap(n);
        check("restored", n, SEC * 32);
        $display("test display done");
        nh = $urandom_range(3, 1);
        nv = $urandom_range(3, 1);
        for (int k = 0; k < 3; k++) begin
            heat <= (k < nh);
            vol <= (k < nv);
            @(posedge clk_i);
            heat <= 1'b0;
            vol <= 1'b0;
            @(posedge clk_i);
        end
        repeat (40) @(posedge clk_i);
        check("out c", meter_far_side_inst.n_c, nh);
        check("out d", meter_far_side_inst.n_d, nv);
        nh = $urandom_range(16'hFFF0, 0);
        wb(1'b1, `ADR_PRESCALE, 32'h2);
        wb(1'b1, `ADR_COUNT_A, nh);
        meter_far_side_inst.send(4, 6);
        repeat (6) @(posedge clk_i);
        wb(1'b0, `ADR_COUNT_A, 32'h0);
        check("count a", rd, nh + 2);
        for (int k = 0; k < 2; k++) begin
            wb(1'b1, `ADR_CONFIG, 32'h0000265F + k);
            heat <= 1'b1;
            @(posedge clk_i);
            heat <= 1'b0;
            n = 0;
            do @(posedge clk_i); while (pc !== 1'b1 && ++n < 50);
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (pc === 1'b1 && n < 50);
            check("width", n, 4 << k);
        end
        check("leak", leak, 0);
        $display("test pulses done");
        wb(1'b1, `ADR_CONFIG, 32'h00002663);
        for (int k = 1; k < 3; k++) begin
            wb(1'b1, `ADR_OUT_CTRL, k);
            repeat (2) @(posedge clk_i);
            check("ctrl out", {30'h0, pd, pc}, k);
        end
        $display("test control done");
        final_report();
    end
endmodule : meter_integration_and_pulse_ctrl_test
